// *** dor_output_route.sv ***
`timescale 1ns/10ps
`default_nettype none
module dor_output_route
    import dor_pkg::*;
#(
    parameter logic [4:0] PRESENT    = PRESENT_DEFAULT,
    parameter int         FAST_DWELL = FAST_DWELL_CYC,
    parameter int         SLOW_DWELL = SLOW_DWELL_CYC
)
(
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_route_wr,
    input  wire logic [7:0]       i_route_subidx,
    input  wire logic [15:0]      i_route_wdata,
    input  wire logic [7:0]       i_rd_subidx,
    output logic      [15:0]      o_route_rdata,
    input  wire logic [7:0]       i_routing_enable,
    input  wire logic [OCW_W-1:0] i_output_control_word,
    input  wire logic [OCW_W-1:0] i_norm_invert,
    input  wire logic [OCW_W-1:0] i_force_enable,
    input  wire logic [OCW_W-1:0] i_force_value,
    input  wire logic             i_encoder_pulse,
    input  wire logic             i_position_pulse,
    output logic      [NUM_OUT-1:0] o_dout,
    output logic                  o_routing_active
);
    logic [15:0]        route_reg [NUM_OUT];
    logic [NUM_OUT-1:0] dout_reg;
    logic [NUM_OUT-1:0] target;
    logic [15:0]        rdata_reg;
    logic               route_en;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    dor_tap_if #(.TAPS(NUM_TAP)) enc_if ();
    dor_tap_if #(.TAPS(NUM_TAP)) pos_if ();

    dor_pulse_div #(.TAPS(NUM_TAP)) u_enc_div
    (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_pulse    (i_encoder_pulse),
        .taps       (enc_if.src)
    );

    dor_pulse_div #(.TAPS(NUM_TAP)) u_pos_div
    (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_pulse    (i_position_pulse),
        .taps       (pos_if.src)
    );

    // Each rising pulse flips the divide-by-2 tap
    AST_ENC_COUNT: assert property ($rose(i_encoder_pulse)
        |=> enc_if.tap[1] != $past(enc_if.tap[1]))
        else $error("Encoder divider did not advance");
    AST_POS_COUNT: assert property ($rose(i_position_pulse)
        |=> pos_if.tap[1] != $past(pos_if.tap[1]))
        else $error("Position divider did not advance");

    // Source level, invalid codes report not valid
    function automatic logic [1:0] src_decode(input logic [7:0] src,
                                              input logic [NUM_TAP-1:0] enc,
                                              input logic [NUM_TAP-1:0] pos);
        logic [7:0] k;
        k = 8'h00;
        if (src == SRC_ONE)
            return 2'b11;
        else if (src == SRC_ZERO)
            return 2'b10;
        else if (src >= SRC_ENC_FIRST && src <= SRC_ENC_LAST)
        begin
            k = src - SRC_ENC_FIRST;
            return {1'b1, enc[k[2:0]]};
        end
        else if (src >= SRC_POS_FIRST && src <= SRC_POS_LAST)
        begin
            k = src - SRC_POS_FIRST;
            return {1'b1, pos[k[2:0]]};
        end
        return 2'b00;
    endfunction : src_decode

    // Control word bit for an output in normal mode
    function automatic int ocw_bit(input int n);
        return (n == 0) ? BRAKE_OCW_BIT : OUT1_OCW_BIT + n - 1;
    endfunction : ocw_bit

    assign route_en         = (i_routing_enable == ROUTE_EN_ON);
    assign o_routing_active = route_en;
    assign o_route_rdata    = rdata_reg;
    assign o_dout           = dout_reg;

    AST_ENABLE_VALUE: assert property (i_routing_enable != ROUTE_EN_ON
        |-> !o_routing_active)
        else $error("Routing active without enable value 1");

    // Route word storage, subindex 01 brake, 02..05 outputs 1..4
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            for (int n = 0; n < NUM_OUT; n++)
                route_reg[n] <= ROUTE_RESET;
        end
        else if (i_route_wr && i_route_subidx >= SUB_FIRST_ROUTE && i_route_subidx <= SUB_LAST_ROUTE)
            route_reg[3'(i_route_subidx - SUB_FIRST_ROUTE)] <= i_route_wdata;
    end

    AST_ROUTE_WRITE: assert property (i_route_wr && i_route_subidx == 8'h02
        |=> route_reg[1] == $past(i_route_wdata))
        else $error("Route word 2 not stored");
    AST_IGNORE_WRITE: assert property (i_route_wr && i_route_subidx > SUB_LAST_ROUTE
        |=> $stable(route_reg[0]) && $stable(route_reg[4]))
        else $error("Write to unknown subindex stored");

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_reg <= 16'h0000;
        else if (i_rd_subidx >= SUB_FIRST_ROUTE && i_rd_subidx <= SUB_LAST_ROUTE)
            rdata_reg <= route_reg[3'(i_rd_subidx - SUB_FIRST_ROUTE)];
        else
            rdata_reg <= 16'h0000;
    end

    AST_READBACK: assert property (i_rd_subidx == 8'h03
        |=> o_route_rdata == $past(route_reg[2]))
        else $error("Readback of route word 3 wrong");

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++)
        begin : g_out
            localparam int          OB    = ocw_bit(g);
            localparam logic [DWELL_W-1:0] DWELL = FAST_MASK[g] ? DWELL_W'(FAST_DWELL) : DWELL_W'(SLOW_DWELL);
            logic [1:0]         src_lvl;
            logic [IDX_MSB:0]   idx;
            logic               gate_on;
            logic               routed;
            logic               normal;
            logic [DWELL_W-1:0] dwell_reg;

            assign idx     = route_reg[g][IDX_MSB:0];
            assign gate_on = (idx < OCW_W) &&
                             (i_output_control_word[idx[4:0]] ^ route_reg[g][INV_BIT]);
            assign src_lvl = src_decode(route_reg[g][SRC_MSB:SRC_LSB], enc_if.tap, pos_if.tap);
            assign routed  = gate_on && src_lvl[1] && src_lvl[0];
            assign normal  = i_force_enable[OB] ? i_force_value[OB]
                                                : (i_output_control_word[OB] ^ i_norm_invert[OB]);
            assign target[g] = PRESENT[g] && (route_en ? routed : normal);

            // Minimum half period per output
            always_ff @(posedge i_core_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                begin
                    dout_reg[g] <= 1'b0;
                    dwell_reg   <= '0;
                end
                else if (dwell_reg != '0)
                    dwell_reg <= dwell_reg - 1'b1;
                else if (target[g] != dout_reg[g])
                begin
                    dout_reg[g] <= target[g];
                    dwell_reg   <= DWELL - 1'b1;
                end
            end
        end
    endgenerate

    // Routed and normal-mode level on output 1 per source and gate setting
    AST_CONST_ONE: assert property (route_en && route_reg[1][15:8] == SRC_ONE && g_out[1].gate_on
        |-> target[1])
        else $error("Constant one not driven");
    AST_CONST_ZERO: assert property (route_en && route_reg[1][15:8] == SRC_ZERO
        |-> !target[1])
        else $error("Constant zero not driven");
    AST_INVERT: assert property (route_en && route_reg[1] == 16'h0085 && !i_output_control_word[5]
        |-> target[1])
        else $error("Inverted gate failed");
    AST_RANGE: assert property (route_en && route_reg[1][6:0] >= 7'h20
        |-> !target[1])
        else $error("Out of range index not gated off");
    AST_BAD_SRC: assert property (route_en && route_reg[1][15:8] > SRC_POS_LAST
        |-> !target[1])
        else $error("Bad source not gated off");
    AST_ENC_DIV1: assert property (route_en && route_reg[1][15:8] == 8'h02 && g_out[1].gate_on
        |-> target[1] == i_encoder_pulse)
        else $error("Encoder pass-through wrong");
    AST_POS_DIV1: assert property (route_en && route_reg[1][15:8] == 8'h09 && g_out[1].gate_on
        |-> target[1] == i_position_pulse)
        else $error("Position pass-through wrong");
    AST_NORMAL: assert property (!route_en && !i_force_enable[16] && !i_norm_invert[16]
        |-> target[1] == i_output_control_word[16])
        else $error("Normal mode wrong");
    AST_GATE_BIT: assert property (route_en && route_reg[1] == 16'h0003
        |-> target[1] == i_output_control_word[3])
        else $error("Gating bit 3 not followed");
    AST_FORCE_IGNORED: assert property (route_en && route_reg[1] == 16'h0003 && i_force_enable[16]
        && !i_force_value[16] && i_output_control_word[3] |-> target[1])
        else $error("Forced value leaked into routing mode");

    // Hold time after each change of output 0 (fast) and output 3 (slow)
    AST_DWELL: assert property ($changed(dout_reg[0])
        |=> $stable(dout_reg[0]) [*8])
        else $error("Output changed too fast");
    AST_SLOW_DWELL: assert property ($changed(dout_reg[3])
        |=> $stable(dout_reg[3]) [*8])
        else $error("Slow output changed too fast");

    COV_ROUTE_ON:  cover property ($rose(route_en));
    COV_ENC_OUT:   cover property (route_en && route_reg[1][15:8] == 8'h04 && $rose(dout_reg[1]));
    COV_POS_OUT:   cover property (route_en && route_reg[1][15:8] == 8'h0a && $rose(dout_reg[1]));
    COV_INVERT_ON: cover property (route_en && route_reg[1][INV_BIT] && $rose(dout_reg[1]));
    COV_ALL_ON:    cover property (route_en && dout_reg == 5'h1f);

endmodule : dor_output_route
`default_nettype wire

// *** dor_pkg.sv ***
package dor_pkg;

    localparam int          NUM_OUT          = 5;
    localparam int          NUM_TAP          = 7;
    localparam int          OCW_W            = 32;
    localparam logic [7:0]  SUB_FIRST_ROUTE  = 8'h01;
    localparam logic [7:0]  SUB_LAST_ROUTE   = 8'h05;
    localparam logic [7:0]  ROUTE_EN_ON      = 8'h01;
    localparam logic [15:0] ROUTE_RESET      = 16'h0100;
    localparam int          SRC_MSB          = 15;
    localparam int          SRC_LSB          = 8;
    localparam int          INV_BIT          = 7;
    localparam int          IDX_MSB          = 6;
    localparam logic [7:0]  SRC_ONE          = 8'h00;
    localparam logic [7:0]  SRC_ZERO         = 8'h01;
    localparam logic [7:0]  SRC_ENC_FIRST    = 8'h02;
    localparam logic [7:0]  SRC_ENC_LAST     = 8'h08;
    localparam logic [7:0]  SRC_POS_FIRST    = 8'h09;
    localparam logic [7:0]  SRC_POS_LAST     = 8'h0f;
    localparam int          BRAKE_OCW_BIT    = 0;
    localparam int          OUT1_OCW_BIT     = 16;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          FAST_HALF_NS     = 50000;
    localparam int          SLOW_HALF_NS     = 1000000;
    localparam int          FAST_DWELL_CYC   = (FAST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SLOW_DWELL_CYC   = (SLOW_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DWELL_W          = 16;
    localparam logic [4:0]  FAST_MASK        = 5'h07;
    localparam logic [4:0]  PRESENT_DEFAULT  = 5'h1f;

endpackage : dor_pkg

// *** dor_tap_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dor_tap_if #(parameter int TAPS = 7);
    logic [TAPS-1:0] tap;
    modport src (output tap);
    modport snk (input  tap);
endinterface : dor_tap_if
`default_nettype wire

// *** dor_pulse_div.sv ***
`timescale 1ns/10ps
`default_nettype none
module dor_pulse_div
    import dor_pkg::*;
#(
    parameter int TAPS = NUM_TAP
)
(
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    input  wire logic i_pulse,
    dor_tap_if.src    taps
);
    logic            pulse_prev_reg;
    logic [TAPS-2:0] count_reg;

    // Edge counter
    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            pulse_prev_reg <= 1'b0;
        else
            pulse_prev_reg <= i_pulse;
    end

    always_ff @(posedge i_core_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            count_reg <= '0;
        else if (i_pulse && !pulse_prev_reg)
            count_reg <= count_reg + 1'b1;
    end

    // Tap 0 is the raw pulse, tap k divides by 2^k
    assign taps.tap = {count_reg, i_pulse};

endmodule : dor_pulse_div
`default_nettype wire

// *** dor_load_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dor_load_model
    import dor_pkg::*;
(
    input  wire logic               i_core_clk,
    input  wire logic [NUM_OUT-1:0] i_pins,
    input  wire logic [2:0]         i_sel,
    input  wire logic               i_clr,
    output logic      [15:0]        o_toggles
);
    logic last_reg;
    // Counts level changes on the selected load
    always_ff @(posedge i_core_clk)
    begin
        last_reg  <= i_pins[i_sel];
        o_toggles <= i_clr ? 16'h0000 : o_toggles + 16'(last_reg != i_pins[i_sel]);
    end
endmodule : dor_load_model
`default_nettype wire

// *** tb_digital_output_routing.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_digital_output_routing
    import dor_pkg::*;
;
    logic               i_core_clk, i_nrst, wr, enc, pos, clr, active;
    logic [7:0]         sub, rsub, en;
    logic [15:0]        wdata, rdata, tog, v;
    logic [OCW_W-1:0]   ocw, inv, fen, fval;
    logic [NUM_OUT-1:0] dout;
    logic [15:0]        rw [6] = '{16'h0003, 16'h0083, 16'h0103, 16'h1003, 16'h0028, 16'h0085};
    logic               ex [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int                 errors = 0, tests_run = 0, cyc = 0;
    dor_output_route #(.FAST_DWELL(9), .SLOW_DWELL(12)) dut_u (
        .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_route_wr(wr), .i_route_subidx(sub),
        .i_route_wdata(wdata), .i_rd_subidx(rsub), .o_route_rdata(rdata), .i_routing_enable(en),
        .i_output_control_word(ocw), .i_norm_invert(inv), .i_force_enable(fen),
        .i_force_value(fval), .i_encoder_pulse(enc), .i_position_pulse(pos), .o_dout(dout),
        .o_routing_active(active));
    dor_load_model load_u (.i_core_clk(i_core_clk), .i_pins(dout), .i_sel(3'h1), .i_clr(clr), .o_toggles(tog));
    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            complete_run();
        end
    end
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr_route(input logic [7:0] s, input logic [15:0] d);
        @(posedge i_core_clk);
        wr    <= 1'b1;
        sub   <= s;
        wdata <= d;
        @(posedge i_core_clk);
        wr    <= 1'b0;
    endtask : wr_route
    task rd_route(input logic [7:0] s, output logic [15:0] d);
        @(posedge i_core_clk);
        rsub <= s;
        repeat (2) @(posedge i_core_clk);
        #1 d = rdata;
    endtask : rd_route
    task settle;
        repeat (14) @(posedge i_core_clk);
        #1;
    endtask : settle
    // Pulse train on encoder or position source, 12 cycles per half period
    task train(input logic use_pos);
        repeat (64)
        begin
            repeat (12) @(posedge i_core_clk);
            enc <= ~use_pos;
            pos <= use_pos;
            repeat (12) @(posedge i_core_clk);
            enc <= 1'b0;
            pos <= 1'b0;
        end
    endtask : train
    initial
    begin
        i_nrst = 1'b0;
        {wr, enc, pos} = 3'h0;
        clr = 1'b1;
        {sub, rsub, en, wdata} = 40'h0;
        {ocw, inv, fen, fval} = 128'h0;
        repeat (8) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        clr    <= 1'b0;
        for (int s = 1; s <= 6; s++)
        begin
            rd_route(8'(s), v);
            check(v, (s <= 5) ? ROUTE_RESET : 16'h0000);
        end
        // Normal mode with enable value 2, then routing mode with enable value 1
        ocw <= 32'h0000_0009;
        en  <= 8'h02;
        settle();
        check(16'(dout[0]), 16'h0001);
        check(16'(active), 16'h0000);
        en <= 8'h01;
        settle();
        check(16'(active), 16'h0001);
        check(16'(dout[0]), 16'h0000);
        // Gating table on output 1 with normal settings set to disturb
        fen <= '1;
        inv <= '1;
        for (int i = 0; i < 6; i++)
        begin
            wr_route(8'h02, rw[i]);
            rd_route(8'h02, v);
            check(v, rw[i]);
            settle();
            check(16'(dout[1]), 16'(ex[i]));
        end
        for (int s = 1; s <= 5; s++)
            wr_route(8'(s), 16'h0003);
        wr_route(8'h06, 16'h0103);
        settle();
        check(16'(dout), 16'h001f);
        // Every divider code on both pulse sources
        for (int k = 0; k < 14; k++)
        begin
            wr_route(8'h02, {8'(2 + k), 8'h03});
            settle();
            clr <= 1'b1;
            @(posedge i_core_clk);
            clr <= 1'b0;
            train(k >= 7);
            settle();
            check(tog, 16'(128 >> (k % 7)));
        end
        complete_run();
    end
endmodule : tb_digital_output_routing
`default_nettype wire
